// ---- hw/bscan_tap.sv ----
/*
 * Boundary-scan test port: TAP controller, instruction register,
 * bypass and identity registers, and the chain of 3-bit scan cells for
 * user I/O pins and dedicated pins.
 * Assumes tck is the scan tester's clock, unrelated to ref_clk, and that
 * the functional core and the pin inputs live in the ref_clk domain.
 */
module bscan_tap
    import bscan_pkg::*;
#(
    parameter logic [bscan_pkg::IR_LEN-1:0] OP_EXTEST   = OP_EXTEST_DEF,
    parameter logic [bscan_pkg::IR_LEN-1:0] OP_SAMPLE   = OP_SAMPLE_DEF,
    parameter logic [bscan_pkg::IR_LEN-1:0] OP_IDCODE   = OP_IDCODE_DEF,
    parameter logic [bscan_pkg::IR_LEN-1:0] OP_USERCODE = OP_USERCODE_DEF,
    parameter logic [bscan_pkg::IR_LEN-1:0] OP_CLAMP    = OP_CLAMP_DEF,
    parameter logic [bscan_pkg::IR_LEN-1:0] OP_HIGHZ    = OP_HIGHZ_DEF,
    parameter logic [bscan_pkg::ID_LEN-1:0] IDCODE_VAL  = IDCODE_DEF,
    parameter logic [bscan_pkg::ID_LEN-1:0] USERCODE_VAL = USERCODE_DEF
) (
    // System clock and reset
    input  logic                           ref_clk,
    input  logic                           rst_n,
    // Test port
    input  logic                           tck,
    input  logic                           tms,
    input  logic                           tdi,
    output logic                           tdo,
    output logic                           tdo_oe,
    // Core side of the user pins
    input  bscan_pkg::bscan_core_t         core_req,
    output logic [bscan_pkg::N_USER-1:0]   core_in_value,
    // Pad side of the user pins
    input  logic [bscan_pkg::N_USER-1:0]   pin_in,
    output bscan_pkg::bscan_pin_t          pin_drv,
    // Dedicated pins, observed only
    input  bscan_pkg::bscan_ded_t          ded
);
    import bscan_pkg::*;

    localparam int TSYNC_W = $bits(bscan_core_t) + N_USER
                           + $bits(bscan_ded_t);

    // ----------------------------------------------------------------
    // Test-clock reset: power-up only, no test reset pin
    // ----------------------------------------------------------------
    logic t_rst1_q;
    logic t_rst_n_q;

    always_ff @(posedge tck) begin
        t_rst1_q  <= rst_n;
        t_rst_n_q <= t_rst1_q;
    end

    // ----------------------------------------------------------------
    // TAP controller
    // ----------------------------------------------------------------
    bscan_tap_state_t state_q;
    bscan_tap_state_t state_d;

    always_comb begin
        unique case (state_q)
            TS_RESET:    state_d = tms ? TS_RESET   : TS_IDLE;
            TS_IDLE:     state_d = tms ? TS_SEL_DR  : TS_IDLE;
            TS_SEL_DR:   state_d = tms ? TS_SEL_IR  : TS_CAP_DR;
            TS_CAP_DR:   state_d = tms ? TS_EX1_DR  : TS_SH_DR;
            TS_SH_DR:    state_d = tms ? TS_EX1_DR  : TS_SH_DR;
            TS_EX1_DR:   state_d = tms ? TS_UPD_DR  : TS_PAUSE_DR;
            TS_PAUSE_DR: state_d = tms ? TS_EX2_DR  : TS_PAUSE_DR;
            TS_EX2_DR:   state_d = tms ? TS_UPD_DR  : TS_SH_DR;
            TS_UPD_DR:   state_d = tms ? TS_SEL_DR  : TS_IDLE;
            TS_SEL_IR:   state_d = tms ? TS_RESET   : TS_CAP_IR;
            TS_CAP_IR:   state_d = tms ? TS_EX1_IR  : TS_SH_IR;
            TS_SH_IR:    state_d = tms ? TS_EX1_IR  : TS_SH_IR;
            TS_EX1_IR:   state_d = tms ? TS_UPD_IR  : TS_PAUSE_IR;
            TS_PAUSE_IR: state_d = tms ? TS_EX2_IR  : TS_PAUSE_IR;
            TS_EX2_IR:   state_d = tms ? TS_UPD_IR  : TS_SH_IR;
            TS_UPD_IR:   state_d = tms ? TS_SEL_DR  : TS_IDLE;
        endcase
    end

    always_ff @(posedge tck) begin
        if (!t_rst_n_q) begin
            state_q <= TS_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // Instruction register and decode
    // ----------------------------------------------------------------
    logic [IR_LEN-1:0] ir_sh_q;
    logic [IR_LEN-1:0] ir_q;
    logic              sel_bsr;
    logic              sel_id;
    logic              sel_byp;
    logic              drv_upd;
    logic              hiz;

    always_ff @(posedge tck) begin
        if (!t_rst_n_q) begin
            ir_sh_q <= '0;
        end else if (state_q == TS_CAP_IR) begin
            ir_sh_q <= {{(IR_LEN-2){1'b0}}, IR_CAP_PAT};
        end else if (state_q == TS_SH_IR) begin
            ir_sh_q <= {tdi, ir_sh_q[IR_LEN-1:1]};
        end
    end

    always_ff @(posedge tck) begin
        if (!t_rst_n_q || state_d == TS_RESET) begin
            ir_q <= OP_IDCODE;
        end else if (state_q == TS_UPD_IR) begin
            ir_q <= ir_sh_q;
        end
    end

    // Unknown codes fall back to bypass so the chain length stays known
    always_comb begin
        sel_bsr = (ir_q == OP_SAMPLE) || (ir_q == OP_EXTEST);
        sel_id  = (ir_q == OP_IDCODE) || (ir_q == OP_USERCODE);
        sel_byp = (ir_q == OP_BYPASS) || !(sel_bsr || sel_id);
        drv_upd = (ir_q == OP_EXTEST) || (ir_q == OP_CLAMP);
        hiz     = (ir_q == OP_HIGHZ);
    end

    // ----------------------------------------------------------------
    // Live signals into the test-clock domain
    // ----------------------------------------------------------------
    logic [TSYNC_W-1:0] t_sync1_q;
    logic [TSYNC_W-1:0] t_sync2_q;
    bscan_core_t        core_t;
    logic [N_USER-1:0]  pin_t;
    bscan_ded_t         ded_t;

    always_ff @(posedge tck) begin
        t_sync1_q <= {core_req, pin_in, ded};
        t_sync2_q <= t_sync1_q;
    end

    assign {core_t, pin_t, ded_t} = t_sync2_q;

    // ----------------------------------------------------------------
    // Capture sources; only user and dedicated signal pins get cells
    // ----------------------------------------------------------------
    logic [CHAIN_LEN-1:0] cap_src;

    always_comb begin
        cap_src = '0;
        for (int i = 0; i < N_USER; i++) begin
            cap_src[CELL_W*i+CB_OUT] = core_t.core_out_value[i];
            cap_src[CELL_W*i+CB_OE]  = core_t.core_oe_value[i];
            cap_src[CELL_W*i+CB_IN]  = pin_t[i];
        end
        for (int k = 0; k < N_DED; k++) begin
            cap_src[CELL_W*(N_USER+k)+CB_OUT] = 1'b0;
            cap_src[CELL_W*(N_USER+k)+CB_OE]  = 1'b1;
            cap_src[CELL_W*(N_USER+k)+CB_IN]  = ded_t.pin_in[k];
        end
        cap_src[CELL_W*(N_USER+DED_OD)+CB_OE]  = ded_t.od_oe;
        cap_src[CELL_W*(N_USER+DED_PP)+CB_OUT] = ded_t.pp_out;
        cap_src[CELL_W*(N_USER+DED_PP)+CB_OE]  = ded_t.pp_oe;
    end

    // ----------------------------------------------------------------
    // Data registers
    // ----------------------------------------------------------------
    logic [CHAIN_LEN-1:0] cap_q;
    logic [CHAIN_LEN-1:0] upd_q;
    logic [ID_LEN-1:0]    id_q;
    logic                 byp_q;

    always_ff @(posedge tck) begin
        if (!t_rst_n_q) begin
            cap_q <= '0;
        end else if (sel_bsr && state_q == TS_CAP_DR) begin
            cap_q <= cap_src;
        end else if (sel_bsr && state_q == TS_SH_DR) begin
            cap_q <= {tdi, cap_q[CHAIN_LEN-1:1]};
        end
    end

    // Dedicated cells keep update bits, but nothing reads them
    always_ff @(posedge tck) begin
        if (!t_rst_n_q) begin
            upd_q <= UPD_RST;
        end else if (sel_bsr && state_q == TS_UPD_DR) begin
            upd_q <= cap_q;
        end
    end

    always_ff @(posedge tck) begin
        if (!t_rst_n_q) begin
            id_q <= '0;
        end else if (sel_id && state_q == TS_CAP_DR) begin
            id_q <= (ir_q == OP_IDCODE) ? IDCODE_VAL : USERCODE_VAL;
        end else if (sel_id && state_q == TS_SH_DR) begin
            id_q <= {tdi, id_q[ID_LEN-1:1]};
        end
    end

    always_ff @(posedge tck) begin
        if (!t_rst_n_q) begin
            byp_q <= 1'b0;
        end else if (sel_byp && state_q == TS_CAP_DR) begin
            byp_q <= 1'b0;
        end else if (sel_byp && state_q == TS_SH_DR) begin
            byp_q <= tdi;
        end
    end

    // ----------------------------------------------------------------
    // Serial output, changed on the falling edge
    // ----------------------------------------------------------------
    logic in_shift;
    logic shift_bit;
    logic tdo_q;
    logic tdo_oe_q;

    always_comb begin
        in_shift  = (state_q == TS_SH_IR) || (state_q == TS_SH_DR);
        shift_bit = 1'b0;
        if (state_q == TS_SH_IR) begin
            shift_bit = ir_sh_q[0];
        end else if (sel_bsr) begin
            shift_bit = cap_q[0];
        end else if (sel_id) begin
            shift_bit = id_q[0];
        end else begin
            shift_bit = byp_q;
        end
    end

    always_ff @(negedge tck) begin
        if (!t_rst_n_q) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_oe_q <= in_shift;
            tdo_q    <= in_shift ? shift_bit : 1'b0;
        end
    end

    assign tdo    = tdo_q;
    assign tdo_oe = tdo_oe_q;

    // ----------------------------------------------------------------
    // Event toggle towards ref_clk
    // ----------------------------------------------------------------
    // Update bits and mode change only with this toggle and then hold
    // for many ref_clk cycles, so ref_clk copies them as a stable word.
    logic evt_tgl_q;

    always_ff @(posedge tck) begin
        if (!t_rst_n_q) begin
            evt_tgl_q <= 1'b0;
        end else if (state_q == TS_UPD_IR
                     || (sel_bsr && state_q == TS_UPD_DR)
                     || (state_d == TS_RESET && state_q != TS_RESET)) begin
            evt_tgl_q <= !evt_tgl_q;
        end
    end

    // ----------------------------------------------------------------
    // Functional side on ref_clk
    // ----------------------------------------------------------------
    logic                 r_tgl1_q;
    logic                 r_tgl2_q;
    logic                 r_tgl3_q;
    logic [N_USER-1:0]    r_pin1_q;
    logic [N_USER-1:0]    r_pin2_q;
    logic [CHAIN_LEN-1:0] upd_r_q;
    logic                 ext_r_q;
    logic                 hiz_r_q;
    bscan_pin_t           pin_drv_q;
    logic [N_USER-1:0]    core_in_q;

    always_ff @(posedge ref_clk) begin
        r_tgl1_q <= evt_tgl_q;
        r_tgl2_q <= r_tgl1_q;
        r_tgl3_q <= r_tgl2_q;
        r_pin1_q <= pin_in;
        r_pin2_q <= r_pin1_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            upd_r_q <= UPD_RST;
            ext_r_q <= 1'b0;
            hiz_r_q <= 1'b0;
        end else if (r_tgl2_q != r_tgl3_q) begin
            upd_r_q <= upd_q;
            ext_r_q <= drv_upd;
            hiz_r_q <= hiz;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_drv_q <= '0;
            core_in_q <= '0;
        end else begin
            for (int i = 0; i < N_USER; i++) begin
                if (ext_r_q) begin
                    pin_drv_q.out[i] <= upd_r_q[CELL_W*i+CB_OUT];
                    pin_drv_q.en[i]  <= !hiz_r_q
                                        && !upd_r_q[CELL_W*i+CB_OE];
                    core_in_q[i]     <= upd_r_q[CELL_W*i+CB_IN];
                end else begin
                    pin_drv_q.out[i] <= core_req.core_out_value[i];
                    pin_drv_q.en[i]  <= !hiz_r_q
                                        && !core_req.core_oe_value[i];
                    core_in_q[i]     <= r_pin2_q[i];
                end
            end
        end
    end

    assign pin_drv       = pin_drv_q;
    assign core_in_value = core_in_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_tlr_five_ones: assert property (
        @(posedge tck) disable iff (!t_rst_n_q)
        tms [*5] |=> state_q == TS_RESET)
        else $error("five tms highs did not reach reset");

    a_tlr_holds_id: assert property (
        @(posedge tck) disable iff (!t_rst_n_q)
        state_q == TS_RESET |-> ir_q == OP_IDCODE && !drv_upd)
        else $error("reset state without identity instruction");

    a_ir_entry_seq: assert property (
        @(posedge tck) disable iff (!t_rst_n_q)
        (state_q == TS_RESET && !tms) ##1 tms ##1 tms ##1 !tms ##1 !tms
        |=> state_q == TS_SH_IR)
        else $error("tms 01100 did not reach shift-ir");

    a_ir_shift_in: assert property (
        @(posedge tck) disable iff (!t_rst_n_q)
        state_q == TS_SH_IR |=>
        ir_sh_q == {$past(tdi), $past(ir_sh_q[IR_LEN-1:1])})
        else $error("instruction bit not shifted in");

    a_tdo_enable: assert property (
        @(posedge tck) disable iff (!t_rst_n_q)
        ##1 tdo_oe_q == in_shift)
        else $error("tdo enable does not follow shift states");

    a_dr_exit_two: assert property (
        @(posedge tck) disable iff (!t_rst_n_q)
        (state_q == TS_SH_DR && tms) ##1 tms |=> state_q == TS_UPD_DR)
        else $error("two tms highs did not reach update-dr");

    a_chain_update: assert property (
        @(posedge tck) disable iff (!t_rst_n_q)
        sel_bsr && state_q == TS_UPD_DR |=> upd_q == $past(cap_q))
        else $error("update bits not loaded from capture bits");

    a_chain_shift: assert property (
        @(posedge tck) disable iff (!t_rst_n_q)
        sel_bsr && state_q == TS_SH_DR |=>
        cap_q[CHAIN_LEN-1] == $past(tdi)
        && cap_q[CHAIN_LEN-2:0] == $past(cap_q[CHAIN_LEN-1:1]))
        else $error("scan chain did not shift");

    a_bypass_one: assert property (
        @(posedge tck) disable iff (!t_rst_n_q)
        sel_byp && state_q == TS_SH_DR |=> byp_q == $past(tdi))
        else $error("bypass bit not taken from tdi");

    a_sample_passes: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !ext_r_q && !hiz_r_q |=>
        pin_drv_q.out == $past(core_req.core_out_value)
        && pin_drv_q.en == ~$past(core_req.core_oe_value))
        else $error("functional path disturbed outside test");

    a_oe_release: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ext_r_q && upd_r_q[CB_OE] |=> !pin_drv_q.en[0])
        else $error("oe update bit of one did not release pin");

endmodule

// ---- hw/bscan_pkg.sv ----
/*
 * Shared constants and types of the boundary-scan test port: register
 * lengths, cell layout, default instruction codes, TAP states and the
 * structs that carry core and pin signals.
 * Assumes bscan_tap and the bench include it by import; nothing else.
 */
package bscan_pkg;

    // ----------------------------------------------------------------
    // Lengths and chain layout
    // ----------------------------------------------------------------
    localparam int IR_LEN    = 10;
    localparam int ID_LEN    = 32;
    localparam int N_USER    = 4;
    localparam int N_DED     = 4;
    localparam int CELL_W    = 3;
    localparam int N_CELLS   = N_USER + N_DED;
    localparam int CHAIN_LEN = CELL_W * N_CELLS;

    // Bit positions inside one cell
    localparam int CB_IN  = 0;
    localparam int CB_OE  = 1;
    localparam int CB_OUT = 2;

    // Dedicated cell order, after the user cells
    localparam int DED_CLK = 0;
    localparam int DED_IN  = 1;
    localparam int DED_OD  = 2;
    localparam int DED_PP  = 3;

    // Update cells come up with the output buffer disabled, driving a zero
    localparam logic [CELL_W-1:0]    CELL_RST = 3'h2;
    localparam logic [CHAIN_LEN-1:0] UPD_RST  = {N_CELLS{CELL_RST}};

    // ----------------------------------------------------------------
    // Default instruction codes and identity values (arbitrary)
    // ----------------------------------------------------------------
    localparam logic [IR_LEN-1:0] OP_EXTEST_DEF   = 10'h000;
    localparam logic [IR_LEN-1:0] OP_SAMPLE_DEF   = 10'h005;
    localparam logic [IR_LEN-1:0] OP_IDCODE_DEF   = 10'h006;
    localparam logic [IR_LEN-1:0] OP_USERCODE_DEF = 10'h007;
    localparam logic [IR_LEN-1:0] OP_CLAMP_DEF    = 10'h00A;
    localparam logic [IR_LEN-1:0] OP_HIGHZ_DEF    = 10'h00B;
    localparam logic [IR_LEN-1:0] OP_BYPASS       = 10'h3FF;
    localparam logic [1:0]        IR_CAP_PAT      = 2'h1;
    localparam logic [ID_LEN-1:0] IDCODE_DEF      = 32'h0000_0001;
    localparam logic [ID_LEN-1:0] USERCODE_DEF    = 32'hFFFF_FFFF;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        TS_RESET, TS_IDLE,
        TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR,
        TS_PAUSE_DR, TS_EX2_DR, TS_UPD_DR,
        TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR,
        TS_PAUSE_IR, TS_EX2_IR, TS_UPD_IR
    } bscan_tap_state_t;

    typedef struct packed {
        logic [N_USER-1:0] core_out_value;
        logic [N_USER-1:0] core_oe_value;
    } bscan_core_t;

    typedef struct packed {
        logic [N_USER-1:0] out;
        logic [N_USER-1:0] en;
    } bscan_pin_t;

    typedef struct packed {
        logic [N_DED-1:0] pin_in;
        logic             pp_out;
        logic             pp_oe;
        logic             od_oe;
    } bscan_ded_t;

endpackage

// ---- dv/bscan_tester.sv ----
/*
 * Scan tester model: runs the test clock only inside transfers, drives
 * mode select and serial data, samples the serial output.
 * Assumes the bench calls step() once for every test clock.
 */
module bscan_tester (
    // Test port, tester side
    output logic tck,
    output logic tms,
    output logic tdi,
    input  logic tdo,
    input  logic tdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    logic oe_seen;

    initial begin
        tck = 1'b0;
        tms = 1'b1;  // Idle high holds the controller in reset
        tdi = 1'b1;
        oe_seen = 1'b0;
    end

    // ------------------------------------------------------------
    // One 125 ns test clock
    // ------------------------------------------------------------
    // Inputs move at the falling edge; tdo is taken just before the
    // rising edge so the device's falling-edge update has settled.
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #61.5;
        q = tdo;
        oe_seen = tdo_oe;
        #1 tck = 1'b1;
        #62.5 tck = 1'b0;
    endtask
endmodule

// ---- dv/tb.sv ----
/*
 * Self-checking bench of the boundary-scan port: instruction load,
 * sample, external test, bypass and reset by mode select.
 * Assumes bscan_tap with default opcodes and the tester model.
 */
module tb import bscan_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic         ref_clk;
    logic         rst_n;
    logic         tck;
    logic         tms;
    logic         tdi;
    logic         tdo;
    logic         tdo_oe;
    bscan_core_t  core_req;
    logic [3:0]   core_in_value;
    logic [3:0]   pin_in;
    bscan_pin_t   pin_drv;
    bscan_ded_t   ded;
    logic [47:0]  so;
    int           fail_count = 0;
    int           tests_run = 0;
    localparam logic [23:0] PAT = 24'h5A3C96;

    bscan_tap bscan_tap_i (.ref_clk(ref_clk), .rst_n(rst_n), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .core_req(core_req), .core_in_value(core_in_value),
        .pin_in(pin_in), .pin_drv(pin_drv), .ded(ded));

    bscan_tester bscan_tester_i (.tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [47:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Mode select bits are sent LSB first
    task automatic tms_seq(input logic [15:0] m, input int n);
        logic q;
        for (int i = 0; i < n; i++) bscan_tester_i.step(m[i], 1'b1, q);
    endtask

    // Last bit goes with mode select high, leaving for Exit1
    task automatic shift(input int n, input logic [47:0] d);
        logic b;
        so = '0;
        for (int i = 0; i < n; i++) begin
            bscan_tester_i.step(i == n - 1, d[i], b);
            so[i] = b;
        end
    endtask

    task automatic ld_ir(input logic [9:0] code);
        tms_seq(16'h0003, 4);
        shift(10, code);
        chk("ir_cap", so[1:0], IR_CAP_PAT);
        chk("oe_shift", bscan_tester_i.oe_seen, 1'b1);
        tms_seq(16'h0001, 2);
        chk("oe_idle", bscan_tester_i.oe_seen, 1'b0);
    endtask

    task automatic dr(input int n, input logic [47:0] d);
        tms_seq(16'h0001, 3);
        shift(n, d);
        tms_seq(16'h0001, 2);
    endtask

    function automatic logic [23:0] exp_chain();
        logic [23:0] c;
        for (int i = 0; i < 4; i++)
            c[3*i +: 3] = {core_req.core_out_value[i],
                core_req.core_oe_value[i], pin_in[i]};
        c[12 +: 3] = {2'b01, ded.pin_in[0]};
        c[15 +: 3] = {2'b01, ded.pin_in[1]};
        c[18 +: 3] = {1'b0, ded.od_oe, ded.pin_in[2]};
        c[21 +: 3] = {ded.pp_out, ded.pp_oe, ded.pin_in[3]};
        return c;
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_sample();
        ld_ir(OP_SAMPLE_DEF);
        repeat (10) @(negedge ref_clk);
        chk("smp_out", pin_drv.out, core_req.core_out_value);
        chk("smp_en", pin_drv.en, 4'(~core_req.core_oe_value));
        chk("smp_in", core_in_value, pin_in);
        dr(48, {PAT, PAT});
        chk("smp_cap", so[23:0], exp_chain());
        chk("smp_pass", so[47:24], PAT);
    endtask

    task automatic t_extest();
        ld_ir(OP_EXTEST_DEF);
        repeat (10) @(negedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            chk("ext_out", pin_drv.out[i], PAT[3*i+2]);
            chk("ext_en", pin_drv.en[i], 1'(~PAT[3*i+1]));
            chk("ext_in", core_in_value[i], PAT[3*i]);
        end
    endtask

    task automatic t_bypass();
        ld_ir(OP_BYPASS);
        dr(8, 48'hB4);
        chk("bypass", so[7:0], 8'h68);
    endtask

    // From Shift-DR, five highs must land in reset with identity loaded
    task automatic t_tms_reset();
        tms_seq(16'h00F9, 9);
        dr(32, 48'h0);
        chk("idcode", so[31:0], IDCODE_DEF);
    endtask

    // Clamp drives the preloaded update bits over a bypass path;
    // high-impedance releases every pin; user code reads its own word
    task automatic t_modes();
        ld_ir(OP_CLAMP_DEF);
        repeat (10) @(negedge ref_clk);
        chk("clp_o", pin_drv.out, {PAT[11], PAT[8], PAT[5], PAT[2]});
        dr(8, 48'hB4);
        chk("clp_byp", so[7:0], 8'h68);
        ld_ir(OP_HIGHZ_DEF);
        repeat (10) @(negedge ref_clk);
        chk("hiz_en", pin_drv.en, 4'h0);
        chk("hiz_in", core_in_value, pin_in);
        ld_ir(OP_USERCODE_DEF);
        dr(32, 48'h0);
        chk("ucode", so[31:0], USERCODE_DEF);
    endtask

    initial begin
        rst_n = 1'b0;
        core_req = {4'hA, 4'h3};
        pin_in = 4'h6;
        ded = {4'h5, 1'b1, 1'b0, 1'b1};
        // Reset spans test clocks too, so the test side sees it
        tms_seq(16'h00FF, 3);
        @(negedge ref_clk);
        rst_n = 1'b1;
        tms_seq(16'h00FF, 3);
        tms_seq(16'h0000, 1);
        t_sample();
        t_extest();
        t_bypass();
        t_tms_reset();
        t_modes();
        report_and_stop();
    end
endmodule
